// ---- common/plrs_pkg.sv ----
package plrs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned REF_CLK_MHZ = 25;
  localparam int unsigned SETTLE_TIME_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_TIME_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned SLIP_WAIT_CYC = 3;
  localparam int unsigned WD_TIMEOUT_CYC = 65536;
  localparam int unsigned LOCK_SEQ_MIN = 5;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned TMR_W = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_DEBUG = 8'h0C;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_WDEN_BIT = 1;
  localparam int unsigned CTRL_TGT_LSB = 4;
  localparam int unsigned CTRL_TGT_W = 4;
  localparam logic [CTRL_TGT_W-1:0] CTRL_TGT_RESET = 4'h5;
  localparam logic CTRL_WDEN_RESET = 1'b1;
  localparam int unsigned DEBUG_FLAG_BIT = 0;
  localparam int unsigned ST_FIELD_LSB = 0;
  localparam int unsigned ST_DONE_BIT = 4;
  localparam int unsigned ST_WDFIRED_BIT = 5;
  localparam int unsigned ST_FIRSTOK_BIT = 6;
  localparam int unsigned CNT_SLIP_LSB = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DISABLE = 4'h1,
    ST_LOCK_START = 4'h2,
    ST_LOCK_WAIT = 4'h3,
    ST_ARM = 4'h4,
    ST_SELECT = 4'h5,
    ST_SLIP_CHECK = 4'h6,
    ST_DONE = 4'h7
  } plrs_state_t;

  typedef struct packed {
    logic enable;
    logic lock_start;
    logic clk_sel;
  } plrs_loop_ctl_t;
endpackage

// ---- core/plrs_watchdog.sv ----
`timescale 1ns/1ns
module plrs_watchdog #(
  parameter int unsigned TIMEOUT = plrs_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned CW = 17
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic arm_i,
  input wire logic kick_i,
  output logic fire_o
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic fire_nxt;

  // ----------------------------------------
  // Timeout counter on the reference clock
  // ----------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
    fire_nxt = 1'b0;
    if (!arm_i || kick_i)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r == CW'(TIMEOUT - 1))
    begin
      cnt_nxt = '0;
      fire_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
      fire_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      fire_o <= fire_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wd_full_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fire_o |-> $past(arm_i) && !$past(kick_i) && $past(cnt_r) == CW'(TIMEOUT - 1))
    else $error("watchdog fired early");
  wd_fire_cv: cover property (@(posedge ref_clk_i) disable iff (rst_i) fire_o);
endmodule

// ---- core/plrs_sequencer.sv ----
// Notes on behaviour
// - A set lock flag alone never proves the loop clock runs.
// - After a good start, later relocks need only one sequence.
// - Never select a loop that is not enabled; CPU would halt.
// - Watchdog counts on reference clock, independent of loop output.
// - Watchdog expiry resets and repeats the loop bring-up.
`timescale 1ns/1ns
module plrs_sequencer #(
  parameter int unsigned WD_TIMEOUT = plrs_pkg::WD_TIMEOUT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic lock_status_flag_i,
  input wire logic slip_flag_i,
  input wire logic heartbeat_i,
  output plrs_pkg::plrs_loop_ctl_t loop_ctl_o,
  output logic watchdog_reset_o,
  output logic done_o
);
  localparam int unsigned CW = plrs_pkg::CNT_W;
  localparam int unsigned TW = plrs_pkg::TMR_W;
  localparam int unsigned GW = plrs_pkg::CTRL_TGT_W;

  plrs_pkg::plrs_state_t state_r, state_nxt;
  plrs_pkg::plrs_loop_ctl_t loop_ctl_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] lock_cnt_r, lock_cnt_nxt;
  logic [CW-1:0] slip_cnt_r, slip_cnt_nxt;
  logic [CW-1:0] seq_tgt_r, seq_tgt_nxt;
  logic [GW-1:0] ctrl_tgt_r, ctrl_tgt_nxt;
  logic ctrl_wden_r, ctrl_wden_nxt;
  logic dbg_flag_r, dbg_flag_nxt;
  logic wd_arm_r, wd_arm_nxt;
  logic wd_fired_r, wd_fired_nxt;
  logic first_ok_r, first_ok_nxt;
  logic done_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic lk_s1_r, lk_s2_r, sl_s1_r, sl_s2_r, hb_s1_r, hb_s2_r, hb_s3_r;
  logic wd_fire;
  logic kick;
  logic start;
  logic acc;

  // ----------------------------------------
  // Pin synchronisers and watchdog
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      sl_s1_r <= 1'b0;
      sl_s2_r <= 1'b0;
      hb_s1_r <= 1'b0;
      hb_s2_r <= 1'b0;
      hb_s3_r <= 1'b0;
    end
    else
    begin
      lk_s1_r <= lock_status_flag_i;
      lk_s2_r <= lk_s1_r;
      sl_s1_r <= slip_flag_i;
      sl_s2_r <= sl_s1_r;
      hb_s1_r <= heartbeat_i;
      hb_s2_r <= hb_s1_r;
      hb_s3_r <= hb_s2_r;
    end
  end

  assign kick = hb_s2_r ^ hb_s3_r;

  plrs_watchdog #(
    .TIMEOUT(WD_TIMEOUT),
    .CW(32)
  ) u_wdog (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .arm_i(wd_arm_r),
    .kick_i(kick),
    .fire_o(wd_fire)
  );

  assign watchdog_reset_o = wd_fire;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    unique case (a)
      plrs_pkg::ADDR_CTRL:
      begin
        d[plrs_pkg::CTRL_WDEN_BIT] = ctrl_wden_r;
        d[plrs_pkg::CTRL_TGT_LSB +: GW] = ctrl_tgt_r;
      end
      plrs_pkg::ADDR_STATUS:
      begin
        d[plrs_pkg::ST_FIELD_LSB +: 4] = state_r;
        d[plrs_pkg::ST_DONE_BIT] = done_o;
        d[plrs_pkg::ST_WDFIRED_BIT] = wd_fired_r;
        d[plrs_pkg::ST_FIRSTOK_BIT] = first_ok_r;
      end
      plrs_pkg::ADDR_COUNT:
      begin
        d[0 +: CW] = lock_cnt_r;
        d[plrs_pkg::CNT_SLIP_LSB +: CW] = slip_cnt_r;
      end
      plrs_pkg::ADDR_DEBUG: d[plrs_pkg::DEBUG_FLAG_BIT] = dbg_flag_r;
      default: d = '0;
    endcase
    return d;
  endfunction

  assign acc = hsel_i && htrans_i[1] && hready_i;
  assign start = wr_pend_r && wr_addr_r == plrs_pkg::ADDR_CTRL && hwdata_i[plrs_pkg::CTRL_START_BIT];

  // ----------------------------------------
  // Sequencer and registers, next values
  // ----------------------------------------
  always_comb
  begin
    wr_pend_nxt = acc && hwrite_i;
    wr_addr_nxt = acc ? haddr_i[7:0] : wr_addr_r;
    hrdata_nxt = (acc && !hwrite_i) ? read_mux(haddr_i[7:0]) : hrdata_o;
    ctrl_tgt_nxt = ctrl_tgt_r;
    ctrl_wden_nxt = ctrl_wden_r;
    dbg_flag_nxt = dbg_flag_r;
    if (wr_pend_r && wr_addr_r == plrs_pkg::ADDR_CTRL)
    begin
      ctrl_wden_nxt = hwdata_i[plrs_pkg::CTRL_WDEN_BIT];
      ctrl_tgt_nxt = hwdata_i[plrs_pkg::CTRL_TGT_LSB +: GW];
    end
    if (wr_pend_r && wr_addr_r == plrs_pkg::ADDR_DEBUG)
    begin
      dbg_flag_nxt = hwdata_i[plrs_pkg::DEBUG_FLAG_BIT];
    end
    state_nxt = state_r;
    loop_ctl_nxt = loop_ctl_o;
    loop_ctl_nxt.lock_start = 1'b0;
    tmr_nxt = tmr_r;
    lock_cnt_nxt = lock_cnt_r;
    slip_cnt_nxt = slip_cnt_r;
    seq_tgt_nxt = seq_tgt_r;
    wd_arm_nxt = wd_arm_r;
    wd_fired_nxt = wd_fired_r;
    first_ok_nxt = first_ok_r;
    done_nxt = done_o;
    unique case (state_r)
      plrs_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = plrs_pkg::ST_DISABLE;
          lock_cnt_nxt = '0;
          slip_cnt_nxt = '0;
          wd_fired_nxt = 1'b0;
          done_nxt = 1'b0;
          tmr_nxt = '0;
          if (first_ok_r)
          begin
            seq_tgt_nxt = CW'(1);
          end
          else if (ctrl_tgt_r < GW'(plrs_pkg::LOCK_SEQ_MIN))
          begin
            seq_tgt_nxt = CW'(plrs_pkg::LOCK_SEQ_MIN);
          end
          else
          begin
            seq_tgt_nxt = CW'(ctrl_tgt_r);
          end
        end
      end
      plrs_pkg::ST_DISABLE:
      begin
        loop_ctl_nxt.enable = 1'b0;
        loop_ctl_nxt.clk_sel = 1'b0;
        tmr_nxt = tmr_r + TW'(1);
        if (tmr_r == TW'(plrs_pkg::SETTLE_CYC - 1))
        begin
          state_nxt = plrs_pkg::ST_LOCK_START;
        end
      end
      plrs_pkg::ST_LOCK_START:
      begin
        loop_ctl_nxt.enable = 1'b1;
        loop_ctl_nxt.lock_start = 1'b1;
        state_nxt = plrs_pkg::ST_LOCK_WAIT;
      end
      plrs_pkg::ST_LOCK_WAIT:
      begin
        if (lk_s2_r)
        begin
          lock_cnt_nxt = lock_cnt_r + CW'(1);
          tmr_nxt = '0;
          // Lock flag only ends one sequence, more may follow
          state_nxt = (lock_cnt_r + CW'(1) >= seq_tgt_r) ? plrs_pkg::ST_ARM : plrs_pkg::ST_DISABLE;
        end
      end
      plrs_pkg::ST_ARM:
      begin
        wd_arm_nxt = ctrl_wden_r;
        state_nxt = plrs_pkg::ST_SELECT;
      end
      plrs_pkg::ST_SELECT:
      begin
        loop_ctl_nxt.clk_sel = 1'b1;
        tmr_nxt = '0;
        state_nxt = plrs_pkg::ST_SLIP_CHECK;
      end
      plrs_pkg::ST_SLIP_CHECK:
      begin
        tmr_nxt = tmr_r + TW'(1);
        if (tmr_r == TW'(plrs_pkg::SLIP_WAIT_CYC - 1))
        begin
          tmr_nxt = '0;
          if (sl_s2_r)
          begin
            loop_ctl_nxt.clk_sel = 1'b0;
            slip_cnt_nxt = slip_cnt_r + CW'(1);
            wd_arm_nxt = 1'b0;
            seq_tgt_nxt = lock_cnt_r + CW'(1);
            state_nxt = plrs_pkg::ST_DISABLE;
          end
          else
          begin
            done_nxt = 1'b1;
            first_ok_nxt = 1'b1;
            dbg_flag_nxt = 1'b0;
            state_nxt = plrs_pkg::ST_DONE;
          end
        end
      end
      plrs_pkg::ST_DONE:
      begin
        if (start)
        begin
          done_nxt = 1'b0;
          wd_arm_nxt = 1'b0;
          tmr_nxt = '0;
          lock_cnt_nxt = '0;
          seq_tgt_nxt = CW'(1);
          state_nxt = plrs_pkg::ST_DISABLE;
        end
      end
      default: state_nxt = plrs_pkg::ST_IDLE;
    endcase
    if (state_r == plrs_pkg::ST_DISABLE || state_r == plrs_pkg::ST_LOCK_START || state_r == plrs_pkg::ST_LOCK_WAIT)
    begin
      dbg_flag_nxt = 1'b1;
    end
    if (wd_fire)
    begin
      // Expiry restarts the full bring-up, good-start flag cleared
      state_nxt = plrs_pkg::ST_DISABLE;
      loop_ctl_nxt = '0;
      tmr_nxt = '0;
      lock_cnt_nxt = '0;
      seq_tgt_nxt = CW'(plrs_pkg::LOCK_SEQ_MIN);
      wd_arm_nxt = 1'b0;
      wd_fired_nxt = 1'b1;
      first_ok_nxt = 1'b0;
      done_nxt = 1'b0;
      dbg_flag_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= plrs_pkg::ST_IDLE;
      loop_ctl_o <= '0;
      tmr_r <= '0;
      lock_cnt_r <= '0;
      slip_cnt_r <= '0;
      seq_tgt_r <= CW'(plrs_pkg::LOCK_SEQ_MIN);
      ctrl_tgt_r <= plrs_pkg::CTRL_TGT_RESET;
      ctrl_wden_r <= plrs_pkg::CTRL_WDEN_RESET;
      dbg_flag_r <= 1'b0;
      wd_arm_r <= 1'b0;
      wd_fired_r <= 1'b0;
      first_ok_r <= 1'b0;
      done_o <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_o <= '0;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      loop_ctl_o <= loop_ctl_nxt;
      tmr_r <= tmr_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      slip_cnt_r <= slip_cnt_nxt;
      seq_tgt_r <= seq_tgt_nxt;
      ctrl_tgt_r <= ctrl_tgt_nxt;
      ctrl_wden_r <= ctrl_wden_nxt;
      dbg_flag_r <= dbg_flag_nxt;
      wd_arm_r <= wd_arm_nxt;
      wd_fired_r <= wd_fired_nxt;
      first_ok_r <= first_ok_nxt;
      done_o <= done_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_o <= hrdata_nxt;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  lock_not_proof_a: assert property (
    state_r == plrs_pkg::ST_LOCK_WAIT && lk_s2_r && !wd_fire && lock_cnt_r + CW'(1) < seq_tgt_r
    |=> state_r == plrs_pkg::ST_DISABLE && !loop_ctl_o.clk_sel)
    else $error("lock flag alone moved toward select");
  sel_needs_en_a: assert property (loop_ctl_o.clk_sel |-> loop_ctl_o.enable)
    else $error("loop selected while disabled");
  sel_after_seq_a: assert property ($rose(loop_ctl_o.clk_sel) |-> lock_cnt_r >= seq_tgt_r)
    else $error("select before final sequence");
  disable_first_a: assert property ($rose(loop_ctl_o.lock_start) |-> $past(!loop_ctl_o.enable))
    else $error("lock start without prior disable");
  wd_armed_a: assert property ($rose(loop_ctl_o.clk_sel) |-> wd_arm_r || !ctrl_wden_r)
    else $error("select without armed watchdog");
  wd_restart_a: assert property (wd_fire |=> state_r == plrs_pkg::ST_DISABLE ##1 !loop_ctl_o.clk_sel)
    else $error("no restart after watchdog expiry");
  slip_relock_a: assert property (
    state_r == plrs_pkg::ST_SLIP_CHECK && tmr_r == TW'(plrs_pkg::SLIP_WAIT_CYC - 1) && sl_s2_r && !wd_fire
    |=> !loop_ctl_o.clk_sel && slip_cnt_r == $past(slip_cnt_r) + CW'(1))
    else $error("slip not followed by relock");
  dbg_flag_a: assert property (state_r == plrs_pkg::ST_LOCK_START |=> dbg_flag_r)
    else $error("debug flag clear during locking");
  done_clean_a: assert property ($rose(done_o) |-> loop_ctl_o.clk_sel && !$past(sl_s2_r))
    else $error("done without clean switch");

  done_cv: cover property ($rose(done_o));
  slip_cv: cover property (state_r == plrs_pkg::ST_SLIP_CHECK ##1 state_r == plrs_pkg::ST_DISABLE);
  wd_cv: cover property (wd_fire ##[1:200] state_r == plrs_pkg::ST_LOCK_WAIT);
endmodule

// ---- bench/plrs_loop_model.sv ----
`timescale 1ns/1ns
module plrs_loop_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire plrs_pkg::plrs_loop_ctl_t loop_ctl_i,
  input wire logic dead_i,
  input wire logic slip_req_i,
  output logic lock_o,
  output logic slip_o,
  output logic heartbeat_o
);
  logic [2:0] lock_cnt_r;
  logic [1:0] beat_cnt_r;
  logic slip_left_r;

  // ----------------------------------------
  // Loop behaviour
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lock_o <= 1'b0;
      slip_o <= 1'b0;
      heartbeat_o <= 1'b0;
      lock_cnt_r <= 3'h0;
      beat_cnt_r <= 2'h0;
      slip_left_r <= 1'b0;
    end
    else
    begin
      if (slip_req_i)
        slip_left_r <= 1'b1;
      if (!loop_ctl_i.enable)
      begin
        lock_o <= 1'b0;
        lock_cnt_r <= 3'h0;
        slip_o <= 1'b0;
      end
      else if (loop_ctl_i.lock_start)
        lock_cnt_r <= 3'h1;
      else if (lock_cnt_r != 3'h0 && !lock_o)
      begin
        lock_cnt_r <= lock_cnt_r + 3'h1;
        lock_o <= (lock_cnt_r == 3'h3);
      end
      if (loop_ctl_i.enable && !loop_ctl_i.lock_start && lock_cnt_r == 3'h3 && slip_left_r)
      begin
        slip_o <= 1'b1;
        slip_left_r <= 1'b0;
      end
      if (loop_ctl_i.enable && lock_o && !dead_i)
      begin
        beat_cnt_r <= beat_cnt_r + 2'h1;
        if (beat_cnt_r == 2'h3)
          heartbeat_o <= !heartbeat_o;
      end
    end
  end
endmodule

// ---- bench/pll_lock_retry_sequencer_tb_top.sv ----
`timescale 1ns/1ns
module pll_lock_retry_sequencer_tb_top;
  localparam int unsigned WD_SIM = 40;
  logic ref_clk_i, rst_i, hsel, hwrite, dead, slip_req, lock_flag, slip_flag, heartbeat;
  logic hreadyout, hresp, wd_reset, done;
  logic [31:0] haddr, hwdata, hrdata, rd, c0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  plrs_pkg::plrs_loop_ctl_t loop_ctl;
  int n_errors, cmp_count, n_starts, s0, i;

  plrs_sequencer #(.WD_TIMEOUT(WD_SIM)) plrs_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .lock_status_flag_i(lock_flag), .slip_flag_i(slip_flag), .heartbeat_i(heartbeat),
    .loop_ctl_o(loop_ctl), .watchdog_reset_o(wd_reset), .done_o(done));

  plrs_loop_model plrs_loop_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .loop_ctl_i(loop_ctl),
    .dead_i(dead), .slip_req_i(slip_req), .lock_o(lock_flag), .slip_o(slip_flag), .heartbeat_o(heartbeat));

  // ----------------------------------------
  // Clock and sequence watcher
  // ----------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
    if (loop_ctl.lock_start === 1'b1)
      n_starts++;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_done;
    i = 0;
    do
    begin
      @(posedge ref_clk_i);
      i++;
    end
    while (done !== 1'b1 && i < 3000);
  endtask

  task automatic results;
    $display("Comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    check("loop_ctl idle", 32'(loop_ctl), 32'h0000_0000);
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0052);
    check("hresp okay", 32'({hreadyout, hresp}), 32'h0000_0002);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    check("status reset", rd, 32'h0000_0000);
    bus(1'b1, 32'h0000_0010, 32'h0000_ffff);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
  endtask

  task automatic test_first;
    s0 = n_starts;
    bus(1'b1, 32'h0000_0000, 32'h0000_0023);
    wait_done();
    check("done first", 32'(done), 32'h0000_0001);
    check("lock starts", 32'(n_starts - s0), 32'h0000_0005);
    check("clk_sel", 32'(loop_ctl.clk_sel), 32'h0000_0001);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    check("seq count", {24'h0, rd[7:0]}, 32'h0000_0005);
    bus(1'b0, 32'h0000_000c, 32'h0000_0000);
    check("debug clear", rd, 32'h0000_0000);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    check("status done", rd, 32'h0000_0057);
  endtask

  task automatic test_slip;
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    c0 = rd;
    s0 = n_starts;
    slip_req <= 1'b1;
    bus(1'b1, 32'h0000_0000, 32'h0000_0023);
    slip_req <= 1'b0;
    wait_done();
    check("done slip", 32'(done), 32'h0000_0001);
    check("relock starts", 32'(n_starts - s0), 32'h0000_0002);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    check("slip count", {24'h0, rd[15:8]}, {24'h0, c0[15:8] + 8'h01});
  endtask

  task automatic test_wd;
    dead <= 1'b1;
    bus(1'b1, 32'h0000_0000, 32'h0000_0023);
    i = 0;
    while (wd_reset !== 1'b1 && i < 1000)
    begin
      @(posedge ref_clk_i);
      i++;
    end
    check("wd fired", 32'(wd_reset), 32'h0000_0001);
    dead <= 1'b0;
    bus(1'b0, 32'h0000_000c, 32'h0000_0000);
    check("debug set", rd, 32'h0000_0001);
    wait_done();
    check("done retry", 32'(done), 32'h0000_0001);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    check("retry count", {24'h0, rd[7:0]}, 32'h0000_0005);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    check("status wd", rd & 32'h0000_0030, 32'h0000_0030);
  endtask

  task automatic test_supervisor;
    dead <= 1'b1;
    bus(1'b1, 32'h0000_0000, 32'h0000_0021);
    wait_done();
    check("done unarmed", 32'(done), 32'h0000_0001);
    i = 0;
    repeat (200)
    begin
      @(posedge ref_clk_i);
      if (wd_reset === 1'b1)
        i++;
    end
    check("wd unarmed", 32'(i), 32'h0000_0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    dead <= 1'b0;
    check("loop_ctl reset", 32'(loop_ctl), 32'h0000_0000);
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    check("ctrl after reset", rd, 32'h0000_0052);
    s0 = n_starts;
    bus(1'b1, 32'h0000_0000, 32'h0000_0003);
    wait_done();
    check("done after reset", 32'(done), 32'h0000_0001);
    check("starts after reset", 32'(n_starts - s0), 32'h0000_0005);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    n_starts = 0;
    rst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    dead = 1'b0;
    slip_req = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_first();
    test_slip();
    test_wd();
    test_supervisor();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    results();
  end
endmodule
